// ===== hdl/bpc_pkg.sv
// Purpose: Shared constants and types for the board power control register bank.
// Assumes: One 40 MHz clock, AXI4-Lite register access with 32-bit data.
// Notes: Addresses are byte addresses of aligned words.
package bpc_pkg;

   localparam logic [31:0] BPC_POWER_ADDR = 32'h1200_0000;
   localparam logic [31:0] BPC_MODEL_ADDR = 32'h2200_0000;
   localparam logic [31:0] BPC_OPTIONS_ADDR = 32'h2200_0004;

   localparam int BPC_SER_PWR_BIT = 0;
   localparam int BPC_USB_PWR_BIT = 1;
   localparam int BPC_LCD_PWR_BIT = 2;
   localparam int BPC_SWITCHER_BIT = 3;
   localparam int BPC_EXP_CLK_OFF_BIT = 4;
   localparam int BPC_FAST_STROBE_BIT = 5;
   localparam int BPC_TTL_UART_BIT = 6;
   localparam int BPC_SCRATCH_BIT = 7;

   localparam logic [7:0] BPC_POWER_RESET = 8'h00;
   localparam logic [1:0] BPC_RESP_OKAY = 2'h0;
   localparam logic [1:0] BPC_RESP_SLVERR = 2'h2;

   localparam int BPC_CLK_PERIOD_NS = 25;
   localparam int BPC_LEGACY_STROBE_NS = 500;
   localparam int BPC_LEGACY_RECOVER_NS = 250;
   localparam int BPC_FAST_STROBE_NS = 100;
   localparam int BPC_FAST_RECOVER_NS = 50;
   localparam logic [7:0] BPC_LEGACY_STROBE_CYC =
      8'((BPC_LEGACY_STROBE_NS + BPC_CLK_PERIOD_NS - 1) / BPC_CLK_PERIOD_NS);
   localparam logic [7:0] BPC_LEGACY_RECOVER_CYC =
      8'((BPC_LEGACY_RECOVER_NS + BPC_CLK_PERIOD_NS - 1) / BPC_CLK_PERIOD_NS);
   localparam logic [7:0] BPC_FAST_STROBE_CYC =
      8'((BPC_FAST_STROBE_NS + BPC_CLK_PERIOD_NS - 1) / BPC_CLK_PERIOD_NS);
   localparam logic [7:0] BPC_FAST_RECOVER_CYC =
      8'((BPC_FAST_RECOVER_NS + BPC_CLK_PERIOD_NS - 1) / BPC_CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      BPC_EXP_IDLE = 2'b00,
      BPC_EXP_STROBE = 2'b01,
      BPC_EXP_RECOVER = 2'b10
   } bpc_exp_state_t;

endpackage

// ===== hdl/bpc_axil_wr.sv
// Purpose: AXI4-Lite write channel slave that turns one write into one pulse.
// Assumes: Address and data may arrive in either order; one write at a time.
// Notes: Only the power control word is writable; other addresses answer SLVERR.
`timescale 1ns/1ps
`default_nettype none
module bpc_axil_wr
   import bpc_pkg::*;
(
   input wire logic aclk,
   input wire logic rst_n,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   output logic wr_pulse,
   output logic [7:0] wr_byte
);
   logic [31:0] addr_q;
   logic [7:0] data_q;
   logic strb_q;
   logic commit;

   assign commit = !awready && !wready && !bvalid;

   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         awready <= 1'b1;
         wready <= 1'b1;
         addr_q <= 32'h0000_0000;
         data_q <= 8'h00;
         strb_q <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            addr_q <= awaddr;
         end else if (commit) begin
            awready <= 1'b1;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            data_q <= wdata[7:0];
            strb_q <= wstrb[0];
         end else if (commit) begin
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp <= BPC_RESP_OKAY;
         wr_pulse <= 1'b0;
         wr_byte <= 8'h00;
      end else begin
         wr_pulse <= commit && strb_q && (addr_q[31:2] == BPC_POWER_ADDR[31:2]);
         wr_byte <= data_q;
         if (commit) begin
            bvalid <= 1'b1;
            bresp <= (addr_q[31:2] == BPC_POWER_ADDR[31:2]) ? BPC_RESP_OKAY : BPC_RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== hdl/bpc_serial_route.sv
// Purpose: Routes the third serial port to line levels or to the aux header.
// Assumes: All inputs are synchronous to aclk.
// Notes: Pin output enables are low while this block drives the pin.
`timescale 1ns/1ps
`default_nettype none
module bpc_serial_route (
   input wire logic aclk,
   input wire logic rst_n,
   input wire logic ttl_enable,
   input wire logic uart_txd,
   output logic uart_rxd,
   output logic line_txd,
   input wire logic line_rxd,
   input wire logic gpio_pin1_out,
   input wire logic gpio_pin1_oe_n,
   input wire logic gpio_pin3_out,
   input wire logic gpio_pin3_oe_n,
   input wire logic hdr_pin3_in,
   output logic hdr_pin1_out,
   output logic hdr_pin1_oe_n,
   output logic hdr_pin3_out,
   output logic hdr_pin3_oe_n
);
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         uart_rxd <= 1'b1;
         line_txd <= 1'b1;
         hdr_pin1_out <= 1'b0;
         hdr_pin1_oe_n <= 1'b1;
         hdr_pin3_out <= 1'b0;
         hdr_pin3_oe_n <= 1'b1;
      end else if (ttl_enable) begin
         // (R10) logic level routing
         uart_rxd <= hdr_pin3_in;
         line_txd <= 1'b1;
         // (R11) overrides header GPIO
         hdr_pin1_out <= uart_txd;
         hdr_pin1_oe_n <= 1'b0;
         hdr_pin3_out <= 1'b0;
         hdr_pin3_oe_n <= 1'b1;
      end else begin
         uart_rxd <= line_rxd;
         line_txd <= uart_txd;
         hdr_pin1_out <= gpio_pin1_out;
         hdr_pin1_oe_n <= gpio_pin1_oe_n;
         hdr_pin3_out <= gpio_pin3_out;
         hdr_pin3_oe_n <= gpio_pin3_oe_n;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/bpc_regs.sv
// Purpose: Board power control, model and options registers over AXI4-Lite.
// Assumes: aresetn is a board reboot, por_n a power-on; both synchronous, active low.
// Notes: The scratch bit survives aresetn; of the two resets only por_n clears it, and a write can clear it.
// Function
// (R1) One 8-bit power control register.
// (R2) Bits 0-2 switch three peripheral supplies.
// (R3) Switcher bit settable only without supply jumper.
// (R4) Switcher powers up set unless jumper fitted.
// (R5) Software leaves switcher bit alone normally.
// (R6) Bit 4 stops the expansion bus clock.
// (R7) Bit 5 selects fast expansion strobes.
// (R8) Fast strobes use much shorter cycles.
// (R9) Software keeps fast strobes off normally.
// (R10) Bit 6 moves serial port to header.
// (R11) Logic level routing overrides header GPIO.
// (R12) Bit 7 scratch survives reboots.
// (R13) Watchdog software marks its restarts there.
// (R14) Read-only model register returns board code.
// (R15) Options bit 0 shows fitted serial option.
// (R16) Supply jumper state is sensed.
// (R17) Switcher write with jumper stays zero.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module bpc_regs
   import bpc_pkg::*;
#(
   // Board identification code; the value is arbitrary.
   parameter logic [2:0] MODEL_CODE = 3'h5
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic por_n,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic supply_bus_jumper,
   input wire logic five_uart_option,
   output logic serial_conv_pwr_en,
   output logic usb_5v_en,
   output logic lcd_5v_en,
   output logic switcher_en,
   output logic exp_clk_run,
   output logic exp_fast_strobes,
   input wire logic exp_cycle_req,
   output logic exp_strobe,
   output logic exp_busy,
   input wire logic uart_txd,
   output logic uart_rxd,
   output logic line_txd,
   input wire logic line_rxd,
   input wire logic gpio_pin1_out,
   input wire logic gpio_pin1_oe_n,
   input wire logic gpio_pin3_out,
   input wire logic gpio_pin3_oe_n,
   input wire logic aux_io_header_pin3_in,
   output logic aux_io_header_pin1_out,
   output logic aux_io_header_pin1_oe_n,
   output logic aux_io_header_pin3_out,
   output logic aux_io_header_pin3_oe_n
);
   logic rst_n;
   logic wr_pulse;
   logic [7:0] wr_byte;
   logic [7:0] power_control;
   logic [7:0] next_power;
   logic jumper_fitted;
   logic option_fitted;
   bpc_exp_state_t exp_state;
   logic [7:0] exp_count;
   logic [7:0] exp_strobe_len;
   logic [7:0] exp_recover_len;

   assign rst_n = aresetn && por_n;

   bpc_axil_wr u_wr (
      .aclk(aclk),
      .rst_n(rst_n),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .wr_pulse(wr_pulse),
      .wr_byte(wr_byte)
   );

   bpc_serial_route u_route (
      .aclk(aclk),
      .rst_n(rst_n),
      .ttl_enable(power_control[BPC_TTL_UART_BIT]),
      .uart_txd(uart_txd),
      .uart_rxd(uart_rxd),
      .line_txd(line_txd),
      .line_rxd(line_rxd),
      .gpio_pin1_out(gpio_pin1_out),
      .gpio_pin1_oe_n(gpio_pin1_oe_n),
      .gpio_pin3_out(gpio_pin3_out),
      .gpio_pin3_oe_n(gpio_pin3_oe_n),
      .hdr_pin3_in(aux_io_header_pin3_in),
      .hdr_pin1_out(aux_io_header_pin1_out),
      .hdr_pin1_oe_n(aux_io_header_pin1_oe_n),
      .hdr_pin3_out(aux_io_header_pin3_out),
      .hdr_pin3_oe_n(aux_io_header_pin3_oe_n)
   );

   // (R16) jumper state sensed
   always_ff @(posedge aclk) begin
      if (!por_n) begin
         jumper_fitted <= 1'b0;
         option_fitted <= 1'b0;
      end else begin
         jumper_fitted <= supply_bus_jumper;
         option_fitted <= five_uart_option;
      end
   end

   // A write replaces the whole byte; the switcher bit is masked when the jumper is in.
   always_comb begin
      next_power = power_control;
      if (wr_pulse) begin
         next_power = wr_byte;
      end
      // (R3) switcher needs jumper absent
      // (R17) masked write stays zero
      if (jumper_fitted) begin
         next_power[BPC_SWITCHER_BIT] = 1'b0;
      end
   end

   // (R1) eight-bit power register
   always_ff @(posedge aclk) begin
      if (!por_n) begin
         power_control <= BPC_POWER_RESET;
         // (R4) power-up switcher default
         power_control[BPC_SWITCHER_BIT] <= !supply_bus_jumper;
      end else if (!aresetn) begin
         // (R12) scratch kept over reboot
         power_control <= {power_control[BPC_SCRATCH_BIT], BPC_POWER_RESET[6:4],
                           power_control[BPC_SWITCHER_BIT] && !jumper_fitted,
                           BPC_POWER_RESET[2:0]};
      end else begin
         power_control <= next_power;
      end
   end

   // (R2) supply gate outputs
   assign serial_conv_pwr_en = power_control[BPC_SER_PWR_BIT];
   assign usb_5v_en = power_control[BPC_USB_PWR_BIT];
   assign lcd_5v_en = power_control[BPC_LCD_PWR_BIT];
   assign switcher_en = power_control[BPC_SWITCHER_BIT];
   // (R7) fast strobe select
   assign exp_fast_strobes = power_control[BPC_FAST_STROBE_BIT];

   // (R6) expansion clock stop
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         exp_clk_run <= 1'b1;
      end else begin
         exp_clk_run <= !next_power[BPC_EXP_CLK_OFF_BIT];
      end
   end

   // (R8) shorter fast cycle timing
   assign exp_strobe_len = power_control[BPC_FAST_STROBE_BIT] ?
                           BPC_FAST_STROBE_CYC : BPC_LEGACY_STROBE_CYC;
   assign exp_recover_len = power_control[BPC_FAST_STROBE_BIT] ?
                            BPC_FAST_RECOVER_CYC : BPC_LEGACY_RECOVER_CYC;

   // A cycle request is ignored while busy or while the expansion clock is stopped.
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         exp_state <= BPC_EXP_IDLE;
         exp_count <= 8'h00;
         exp_strobe <= 1'b0;
         exp_busy <= 1'b0;
      end else begin
         case (exp_state)
            BPC_EXP_IDLE: begin
               if (exp_cycle_req && exp_clk_run) begin
                  exp_state <= BPC_EXP_STROBE;
                  exp_count <= exp_strobe_len - 8'h01;
                  exp_strobe <= 1'b1;
                  exp_busy <= 1'b1;
               end
            end
            BPC_EXP_STROBE: begin
               if (exp_count == 8'h00) begin
                  exp_state <= BPC_EXP_RECOVER;
                  exp_count <= exp_recover_len - 8'h01;
                  exp_strobe <= 1'b0;
               end else begin
                  exp_count <= exp_count - 8'h01;
               end
            end
            BPC_EXP_RECOVER: begin
               if (exp_count == 8'h00) begin
                  exp_state <= BPC_EXP_IDLE;
                  exp_busy <= 1'b0;
               end else begin
                  exp_count <= exp_count - 8'h01;
               end
            end
            default: begin
               exp_state <= BPC_EXP_IDLE;
               exp_count <= 8'h00;
               exp_strobe <= 1'b0;
               exp_busy <= 1'b0;
            end
         endcase
      end
   end

   // Read channel: one read at a time, answered the cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= BPC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= BPC_RESP_OKAY;
         if (s_axi_araddr[31:2] == BPC_POWER_ADDR[31:2]) begin
            s_axi_rdata <= {24'h00_0000, power_control};
         end else if (s_axi_araddr[31:2] == BPC_MODEL_ADDR[31:2]) begin
            // (R14) fixed model code
            s_axi_rdata <= {29'h0000_0000, MODEL_CODE};
         end else if (s_axi_araddr[31:2] == BPC_OPTIONS_ADDR[31:2]) begin
            // (R15) fitted option bit
            s_axi_rdata <= {31'h0000_0000, option_fitted};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= BPC_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// ===== test/bpc_regs_chk.sv
// Purpose: Port-level checks for the board power control register bank.
// Assumes: One clock; both resets synchronous and active low.
// Notes: Attached to every bpc_regs instance by the bind below.
`timescale 1ns/1ps
`default_nettype none
module bpc_regs_chk
   import bpc_pkg::*;
#(
   parameter logic [2:0] MODEL_CODE = 3'h5
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic por_n,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic supply_bus_jumper,
   input wire logic switcher_en,
   input wire logic exp_clk_run,
   input wire logic exp_fast_strobes,
   input wire logic exp_cycle_req,
   input wire logic exp_strobe,
   input wire logic exp_busy,
   input wire logic uart_txd,
   input wire logic gpio_pin1_oe_n,
   input wire logic aux_io_header_pin1_out,
   input wire logic aux_io_header_pin1_oe_n
);
   logic [7:0] strobe_cnt;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn || !por_n);

   // Length of the strobe now ending.
   always_ff @(posedge aclk) begin
      if (!aresetn || !por_n) begin
         strobe_cnt <= 8'h00;
      end else if (exp_strobe) begin
         strobe_cnt <= strobe_cnt + 8'h01;
      end else begin
         strobe_cnt <= 8'h00;
      end
   end

   a_jumper_blocks_sw: assert property (supply_bus_jumper [*4] |-> !switcher_en)
      else $error("switcher on with jumper fitted");
   a_exp_gate: assert property ($rose(exp_strobe) |->
      $past(exp_clk_run) && $past(exp_cycle_req))
      else $error("strobe without request or clock");
   a_strobe_len: assert property ($fell(exp_strobe) |->
      strobe_cnt == (exp_fast_strobes ? BPC_FAST_STROBE_CYC : BPC_LEGACY_STROBE_CYC))
      else $error("strobe length wrong");
   a_fast_recover: assert property ($fell(exp_strobe) && exp_fast_strobes |->
      exp_busy ##1 exp_busy ##1 !exp_busy)
      else $error("fast recovery length wrong");
   a_slow_recover: assert property ($fell(exp_strobe) && !exp_fast_strobes |->
      exp_busy [*8] ##1 exp_busy [*2] ##1 !exp_busy)
      else $error("legacy recovery length wrong");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_model_code: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == BPC_MODEL_ADDR |=> s_axi_rdata == {29'h0, MODEL_CODE})
      else $error("model code wrong");
   a_ttl_route: assert property (!aux_io_header_pin1_oe_n && $past(gpio_pin1_oe_n) |->
      aux_io_header_pin1_out == $past(uart_txd))
      else $error("header pin1 not carrying transmit");
endmodule

bind bpc_regs bpc_regs_chk #(.MODEL_CODE(MODEL_CODE)) u_chk (.*);
`default_nettype wire

// ===== test/bpc_regs_tb_top.sv
// Purpose: Register-level testbench for the board power control bank.
// Assumes: AXI4-Lite master tasks; 40 MHz clock.
// Notes: Inputs change by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module bpc_regs_tb_top
   import bpc_pkg::*;
;
   // Board code for this run; the value is arbitrary.
   localparam logic [2:0] MODEL_CODE = 3'h6;
   logic aclk = 1'h0;
   logic aresetn, por_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic supply_bus_jumper, five_uart_option, serial_conv_pwr_en, usb_5v_en, lcd_5v_en;
   logic switcher_en, exp_clk_run, exp_fast_strobes, exp_cycle_req, exp_strobe, exp_busy;
   logic uart_txd, uart_rxd, line_txd, line_rxd, gpio_pin1_out, gpio_pin1_oe_n;
   logic gpio_pin3_out, gpio_pin3_oe_n, aux_io_header_pin3_in, aux_io_header_pin1_out;
   logic aux_io_header_pin1_oe_n, aux_io_header_pin3_out, aux_io_header_pin3_oe_n;
   int mismatches = 0;
   int check_count = 0;

   bpc_regs #(.MODEL_CODE(MODEL_CODE)) uut (.*);

   always #12.5 aclk = ~aclk;

   task automatic final_report;
      if (mismatches == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tmo(input int n);
      if (n >= 60) begin
         mismatches++;
         final_report();
      end
   endtask

   task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input int hold = 0);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= (hold == 0);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (n == hold) s_axi_bready <= 1'h1;
      end while (!(s_axi_bvalid && s_axi_bready) && n < 60);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
      tmo(n);
   endtask

   task automatic rdw(input logic [31:0] a, input int hold = 0);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= (hold == 0);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (n == hold) s_axi_rready <= 1'h1;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 60);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      tmo(n);
   endtask

   task automatic pw(input logic [7:0] d);
      wr(BPC_POWER_ADDR, {24'h0, d}, 4'h1);
      chk("bresp", 32'(resp), 32'(BPC_RESP_OKAY));
   endtask

   task automatic rchk(input logic [31:0] a, exp);
      rdw(a);
      chk("rdata", rd, exp);
   endtask

   task automatic do_reset(input logic por);
      @(posedge aclk);
      aresetn <= 1'h0;
      por_n <= !por;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      por_n <= 1'h1;
   endtask

   task automatic exp_run(input int s, r);
      int ns;
      int nb;
      ns = 0;
      nb = 0;
      @(posedge aclk);
      exp_cycle_req <= 1'h1;
      @(posedge aclk);
      exp_cycle_req <= 1'h0;
      repeat (40) begin
         @(posedge aclk);
         if (exp_strobe === 1'h1) ns++;
         else if (exp_busy === 1'h1) nb++;
      end
      chk("strobe", 32'(ns), 32'(s));
      chk("recover", 32'(nb), 32'(r));
   endtask

   initial begin
      {aresetn, por_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {s_axi_wstrb, s_axi_awprot, s_axi_arprot, supply_bus_jumper, five_uart_option} = '0;
      {exp_cycle_req, uart_txd, line_rxd, gpio_pin1_out, gpio_pin3_out} = '0;
      {gpio_pin1_oe_n, gpio_pin3_oe_n, aux_io_header_pin3_in} = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      por_n <= 1'h1;
      rchk(BPC_POWER_ADDR, 32'h08);
      for (int i = 0; i < 8; i++) begin
         pw(8'h01 << i);
         rchk(BPC_POWER_ADDR, 32'h1 << i);
         chk("outs", {exp_fast_strobes, !exp_clk_run, switcher_en, lcd_5v_en, usb_5v_en,
            serial_conv_pwr_en}, (32'h1 << i) & 32'h3F);
      end
      wr(32'h1300_0000, 32'hFF, 4'hF);
      chk("unmapped wr", 32'(resp), 32'(BPC_RESP_SLVERR));
      wr(BPC_MODEL_ADDR, 32'h7, 4'hF);
      chk("model wr", 32'(resp), 32'(BPC_RESP_SLVERR));
      wr(BPC_POWER_ADDR, 32'h01, 4'h0, 4);
      chk("held bresp", 32'(resp), 32'(BPC_RESP_OKAY));
      rchk(BPC_POWER_ADDR, 32'h80);
      rchk(32'h1300_0000, 32'h0);
      chk("unmapped rd", 32'(resp), 32'(BPC_RESP_SLVERR));
      rchk(BPC_MODEL_ADDR, {29'h0, MODEL_CODE});
      rdw(BPC_MODEL_ADDR, 3);
      chk("held rdata", rd, {29'h0, MODEL_CODE});
      five_uart_option <= 1'h1;
      rchk(BPC_OPTIONS_ADDR, 32'h1);
      five_uart_option <= 1'h0;
      rchk(BPC_OPTIONS_ADDR, 32'h0);
      supply_bus_jumper <= 1'h1;
      pw(8'h0F);
      rchk(BPC_POWER_ADDR, 32'h07);
      chk("sw_en", 32'(switcher_en), 32'h0);
      supply_bus_jumper <= 1'h0;
      pw(8'hFF);
      do_reset(1'h0);
      rchk(BPC_POWER_ADDR, 32'h88);
      do_reset(1'h1);
      rchk(BPC_POWER_ADDR, 32'h08);
      supply_bus_jumper <= 1'h1;
      do_reset(1'h1);
      rchk(BPC_POWER_ADDR, 32'h00);
      supply_bus_jumper <= 1'h0;
      pw(8'h00);
      exp_run(20, 10);
      pw(8'h20);
      exp_run(4, 2);
      pw(8'h10);
      exp_run(0, 0);
      for (int m = 1; m >= 0; m--) begin
         pw({1'h0, m[0], 6'h0});
         for (int v = 0; v < 2; v++) begin
            @(posedge aclk);
            uart_txd <= v[0];
            line_rxd <= v[0];
            aux_io_header_pin3_in <= !v[0];
            gpio_pin1_out <= !v[0];
            gpio_pin1_oe_n <= v[0];
            gpio_pin3_out <= v[0];
            gpio_pin3_oe_n <= v[0];
            repeat (3) @(posedge aclk);
            chk("route", {aux_io_header_pin1_out, aux_io_header_pin1_oe_n,
               aux_io_header_pin3_oe_n, aux_io_header_pin3_out, line_txd, uart_rxd},
               m[0] ? {v[0], 4'h5, !v[0]} : {!v[0], {5{v[0]}}});
         end
      end
      final_report();
   end
endmodule
`default_nettype wire
